//--- gadc_checker_asserts.sv
// Port-level checker for the converter sequencer
`timescale 1ns/1ps
module gadc_checker (
    // Clock and reset
    input wire logic        clk,
    input wire logic        srst,
    // Register bus
    input wire logic [4:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    // Converter and system
    input wire logic        adc_power_on,
    input wire logic        adc_sample,
    input wire logic        irq,
    input wire logic        shutdown_req
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    logic       force_q;
    logic       mask_wr_q;
    logic [7:0] idle_q;
    wire        wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
    wire        rd_ok = avs_read && !avs_waitrequest;

    // Host view of force and mask writes
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            force_q   <= 1'b0;
            mask_wr_q <= 1'b0;
        end
        else if (wr_ok && avs_address == 5'h1)
            force_q <= avs_writedata[1];
        else if (wr_ok && avs_address == 5'h3)
            mask_wr_q <= 1'b1;
    end

    // Cycles since last sample; saturates so old conversions count as settled
    always_ff @(posedge clk)
    begin
        if (srst || adc_sample)
            idle_q <= 8'h0;
        else if (idle_q != 8'hff)
            idle_q <= idle_q + 8'h1;
    end

    property p_sample_powered;
        adc_sample |-> adc_power_on;
    endproperty
    a_sample_powered: assert property (p_sample_powered) else $error("sample unpowered");

    property p_power_request;
        $rose(adc_power_on) && !force_q |-> ##[1:8] adc_sample;
    endproperty
    a_power_request: assert property (p_power_request) else $error("power without sample");

    property p_force_on;
        force_q && $past(force_q, 4) |-> adc_power_on;
    endproperty
    a_force_on: assert property (p_force_on) else $error("forced power low");

    property p_start;
        wr_ok && avs_address == 5'h0 && avs_writedata[7] && avs_writedata[5:4] != 2'b00 |-> ##[1:60] adc_sample;
    endproperty
    a_start: assert property (p_start) else $error("start not launched");

    property p_res_width;
        rd_ok && avs_address inside {5'h4, 5'hc, 5'he, 5'h10} |-> avs_readdata[31:4] == 28'h0;
    endproperty
    a_res_width: assert property (p_res_width) else $error("result high too wide");

    property p_masked;
        !mask_wr_q |-> !irq;
    endproperty
    a_masked: assert property (p_masked) else $error("irq while masked");

    property p_shdn_hold;
        shutdown_req |=> shutdown_req;
    endproperty
    a_shdn_hold: assert property (p_shdn_hold) else $error("shutdown dropped");

    property p_irq_clear;
        wr_ok && avs_address == 5'h2 && avs_writedata[3:0] == 4'hf && idle_q > 8'd60 |-> ##[1:3] !irq;
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("irq stuck");
endmodule // gadc_checker

bind gadc_sequencer gadc_checker chk_u (.clk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .adc_power_on, .adc_sample, .irq, .shutdown_req);

//--- gadc_core_model.sv
// Behavioural analogue converter core facing the sequencer
`timescale 1ns/1ps
module gadc_core_model #(
    parameter int LAT = 10
) (
    // Control from the sequencer
    input wire logic       clk,
    input wire logic       adc_power_on,
    input wire logic       adc_sample,
    input wire logic [3:0] adc_channel,
    // Code back and probes for the bench
    output logic [11:0]    adc_code,
    output logic [7:0]     sample_count,
    output logic [3:0]     last_chan
);
    int left = 0;

    // Code settles LAT cycles after a powered sample; toggles so an early take shows
    always @(posedge clk)
    begin
        if (left > 1)
            adc_code <= ~adc_code;
        else if (left == 1)
            adc_code <= 12'h100 + 12'h111 * {8'h0, last_chan};
        if (left > 0)
            left <= left - 1;
        if (adc_sample && adc_power_on)
        begin
            last_chan    <= adc_channel;
            sample_count <= sample_count + 8'h1;
            left         <= LAT;
        end
    end

    // Known start values
    initial
    begin
        adc_code     = 12'h0;
        sample_count = 8'h0;
        last_chan    = 4'h0;
    end
endmodule // gadc_core_model

//--- gadc_params.svh
// Register offsets, field positions, reset values and timing counts of the converter sequencer
`ifndef GADC_PARAMS_SVH
`define GADC_PARAMS_SVH
`define GADC_OFF_SW_SEL      5'h0
`define GADC_OFF_CTRL1       5'h1
`define GADC_OFF_INT3_STAT   5'h2
`define GADC_OFF_THIRD_INTERRUPT_MASK   5'h3
`define GADC_OFF_SWRES_HI    5'h4
`define GADC_OFF_SWRES_LO    5'h5
`define GADC_OFF_AUTO_SEL    5'h6
`define GADC_OFF_AUTO_CTRL   5'h7
`define GADC_OFF_THR0_HI     5'h8
`define GADC_OFF_THR0_LO     5'h9
`define GADC_OFF_THR1_HI     5'ha
`define GADC_OFF_THR1_LO     5'hb
`define GADC_OFF_AUTO0_HI    5'hc
`define GADC_OFF_AUTO0_LO    5'hd
`define GADC_OFF_AUTO1_HI    5'he
`define GADC_OFF_AUTO1_LO    5'hf
`define GADC_OFF_SWRES1_HI   5'h10
`define GADC_OFF_SWRES1_LO   5'h11
`define GADC_OFF_SWITCH_OFF_DELAY   5'h12
// Software selection fields
`define GADC_SW_EN_BIT       7
`define GADC_SW_START0_BIT   4
`define GADC_SW_START1_BIT   5
// Control one fields
`define GADC_FORCE_BIT       1
// Interrupt status/mask bits
`define GADC_INT_EOC0        0
`define GADC_INT_EOC1        1
`define GADC_INT_AUTO0       2
`define GADC_INT_AUTO1       3
`define GADC_MASK_RESET      8'h0f
// Automatic control fields
`define GADC_AUTO_EN0_BIT    4
`define GADC_AUTO_EN1_BIT    5
`define GADC_SHDN0_BIT       6
`define GADC_SHDN1_BIT       7
// Threshold high: polarity bit
`define GADC_POL_BIT         7
// Timing
`define GADC_CLK_HZ          20000000
`define GADC_CONV_TIME_NS    1000
`define GADC_CONV_CYC        ((`GADC_CONV_TIME_NS * 20 + 999) / 1000)
`define GADC_PWRUP_CYC       4
`define GADC_RATE_UNIT_CYC   16'd20000
`define GADC_SWOFF_UNIT_CYC  16'd20000
`endif

//--- gadc_pkg.sv
// Types shared by the converter sequencer
package gadc_pkg;
    typedef enum logic [3:0] {
        GADC_IDLE  = 4'b0001,
        GADC_PWRUP = 4'b0010,
        GADC_CONV  = 4'b0100,
        GADC_DONE  = 4'b1000
    } gadc_state_e;

    typedef struct packed {
        logic [3:0] chan;
        logic       slot;
        logic       is_auto;
    } gadc_job_s;

    typedef struct packed {
        logic        pol;
        logic [11:0] level;
    } gadc_thr_s;
endpackage

//--- gadc_sequencer.sv
// General converter conversion sequencer with Avalon-MM register slave
`timescale 1ns/1ps
`include "gadc_params.svh"

// Notes on behaviour
// - Software conversion uses host-selected channel
// - Converter powers per request, or forced on
// - End-of-conversion interrupt gated by mask bit
// - Start bit launches one conversion, sets flag
// - Result twelve bits, split high/low registers
// - Automatic slot converts its selected channel
// - Counter field sets automatic repetition rate
// - Automatic result compared with threshold pair
// - Polarity bit selects above or below
// - Shutdown enable makes threshold request shutdown
// - Automatic runs only when enabled; masked interrupt
// - Threshold crossing sets automatic threshold flag
// - Automatic results stored in dedicated registers
// - Shutdown after delay unless flag cleared
// - Second slot mirrors the first slot
module gadc_sequencer
    import gadc_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // Avalon-MM slave
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // Analogue converter core
    output logic             adc_power_on,
    output logic             adc_sample,
    output logic [3:0]       adc_channel,
    input  wire logic [11:0] adc_code,
    // System
    output logic             irq,
    output logic             shutdown_req
);

    // Registers
    logic [7:0]  sw_sel_q;
    logic [7:0]  ctrl1_q;
    logic [7:0]  auto_sel_q;
    logic [7:0]  auto_ctrl_q;
    logic [7:0]  mask_q;
    logic [3:0]  stat_q;
    logic [7:0]  thr_hi_q [2];
    logic [7:0]  thr_lo_q [2];
    logic [11:0] sw_res_q [2];
    logic [11:0] auto_res_q [2];
    logic [7:0]  switch_off_delay_q;

    // Sequencer state
    gadc_state_e state_q;
    gadc_job_s   job_q;
    logic [1:0]  sw_pend_q;
    logic [1:0]  auto_pend_q;
    logic [15:0] unit_cnt_q;
    logic [3:0]  rate_cnt_q;
    logic [15:0] cyc_cnt_q;
    logic [11:0] code_sync1_q;
    logic [11:0] code_sync2_q;
    logic [1:0]  shdn_arm_q;
    logic [15:0] off_unit_q;
    logic [7:0]  off_cnt_q;

    // Bus decode, event and tick strobes
    logic        wr_stb;
    logic        rd_stb;
    logic        rd_busy_q;
    logic [3:0]  set_ev;
    logic [3:0]  clr_ev;
    logic        job_done;
    logic        thr_hit;
    logic        tick;

    // Threshold check with selectable polarity
    function automatic logic thr_cross(input logic [11:0] code, input gadc_thr_s t);
        thr_cross = t.pol ? (code < t.level) : (code > t.level);
    endfunction

    function automatic gadc_thr_s thr_of(input logic [7:0] hi, input logic [7:0] lo);
        thr_of.pol   = hi[`GADC_POL_BIT];
        thr_of.level = {hi[3:0], lo};
    endfunction

    // Writes land only at the edge where waitrequest is low; reads answer a cycle later
    assign wr_stb = avs_write && avs_byteenable[0] && !avs_waitrequest;
    assign rd_stb = avs_read && !rd_busy_q;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            rd_busy_q       <= 1'b0;
            avs_waitrequest <= 1'b1;
        end
        else
        begin
            rd_busy_q       <= rd_stb;
            // Waitrequest low in the cycle after a read is seen, and on writes
            avs_waitrequest <= !(rd_stb || (avs_write && !rd_busy_q && avs_waitrequest));
        end
    end

    // Read data mux, unmapped offsets read zero
    always_ff @(posedge clk)
    begin
        if (srst)
            avs_readdata <= 32'h0;
        else if (rd_stb)
        begin
            avs_readdata <= 32'h0;
            case (avs_address)
                `GADC_OFF_SW_SEL:    avs_readdata[7:0] <= {sw_sel_q[7:6], 2'b00, sw_sel_q[3:0]};
                `GADC_OFF_CTRL1:     avs_readdata[7:0] <= ctrl1_q;
                `GADC_OFF_INT3_STAT: avs_readdata[3:0] <= stat_q;
                `GADC_OFF_THIRD_INTERRUPT_MASK: avs_readdata[7:0] <= mask_q;
                `GADC_OFF_SWRES_HI:  avs_readdata[3:0] <= sw_res_q[0][11:8];
                `GADC_OFF_SWRES_LO:  avs_readdata[7:0] <= sw_res_q[0][7:0];
                `GADC_OFF_AUTO_SEL:  avs_readdata[7:0] <= auto_sel_q;
                `GADC_OFF_AUTO_CTRL: avs_readdata[7:0] <= auto_ctrl_q;
                `GADC_OFF_THR0_HI:   avs_readdata[7:0] <= thr_hi_q[0];
                `GADC_OFF_THR0_LO:   avs_readdata[7:0] <= thr_lo_q[0];
                `GADC_OFF_THR1_HI:   avs_readdata[7:0] <= thr_hi_q[1];
                `GADC_OFF_THR1_LO:   avs_readdata[7:0] <= thr_lo_q[1];
                `GADC_OFF_AUTO0_HI:  avs_readdata[3:0] <= auto_res_q[0][11:8];
                `GADC_OFF_AUTO0_LO:  avs_readdata[7:0] <= auto_res_q[0][7:0];
                `GADC_OFF_AUTO1_HI:  avs_readdata[3:0] <= auto_res_q[1][11:8];
                `GADC_OFF_AUTO1_LO:  avs_readdata[7:0] <= auto_res_q[1][7:0];
                `GADC_OFF_SWRES1_HI: avs_readdata[3:0] <= sw_res_q[1][11:8];
                `GADC_OFF_SWRES1_LO: avs_readdata[7:0] <= sw_res_q[1][7:0];
                `GADC_OFF_SWITCH_OFF_DELAY: avs_readdata[7:0] <= switch_off_delay_q;
                default:             avs_readdata <= 32'h0;
            endcase
        end
    end

    // Plain configuration registers
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            sw_sel_q    <= 8'h00;
            ctrl1_q     <= 8'h00;
            auto_sel_q  <= 8'h00;
            auto_ctrl_q <= 8'h00;
            mask_q      <= `GADC_MASK_RESET;
            thr_hi_q[0] <= 8'h00;
            thr_lo_q[0] <= 8'h00;
            thr_hi_q[1] <= 8'h00;
            thr_lo_q[1] <= 8'h00;
            switch_off_delay_q <= 8'h01;
        end
        else if (wr_stb)
        begin
            case (avs_address)
                `GADC_OFF_SW_SEL:    sw_sel_q    <= {avs_writedata[7:6], 2'b00, avs_writedata[3:0]};
                `GADC_OFF_CTRL1:     ctrl1_q     <= avs_writedata[7:0];
                `GADC_OFF_THIRD_INTERRUPT_MASK: mask_q      <= avs_writedata[7:0];
                `GADC_OFF_AUTO_SEL:  auto_sel_q  <= avs_writedata[7:0];
                `GADC_OFF_AUTO_CTRL: auto_ctrl_q <= avs_writedata[7:0];
                `GADC_OFF_THR0_HI:   thr_hi_q[0] <= avs_writedata[7:0];
                `GADC_OFF_THR0_LO:   thr_lo_q[0] <= avs_writedata[7:0];
                `GADC_OFF_THR1_HI:   thr_hi_q[1] <= avs_writedata[7:0];
                `GADC_OFF_THR1_LO:   thr_lo_q[1] <= avs_writedata[7:0];
                `GADC_OFF_SWITCH_OFF_DELAY: switch_off_delay_q <= avs_writedata[7:0];
                default:             ;
            endcase
        end
    end

    // Start bits are self-clearing pulses; only honoured with software mode on
    always_ff @(posedge clk)
    begin
        if (srst)
            sw_pend_q <= 2'b00;
        else
        begin
            if (job_done && !job_q.is_auto)
                sw_pend_q[job_q.slot] <= 1'b0;
            if (wr_stb && avs_address == `GADC_OFF_SW_SEL && avs_writedata[`GADC_SW_EN_BIT])
            begin
                if (avs_writedata[`GADC_SW_START0_BIT])
                    sw_pend_q[0] <= 1'b1;
                if (avs_writedata[`GADC_SW_START1_BIT])
                    sw_pend_q[1] <= 1'b1;
            end
        end
    end

    // Rate base tick and repetition counter for automatic slots
    assign tick = (unit_cnt_q == `GADC_RATE_UNIT_CYC - 16'd1);

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            unit_cnt_q  <= 16'h0;
            rate_cnt_q  <= 4'h0;
            auto_pend_q <= 2'b00;
        end
        else
        begin
            unit_cnt_q <= tick ? 16'h0 : unit_cnt_q + 16'h1;
            if (job_done && job_q.is_auto)
                auto_pend_q[job_q.slot] <= 1'b0;
            if (tick)
            begin
                if (rate_cnt_q >= auto_ctrl_q[3:0])
                begin
                    rate_cnt_q  <= 4'h0;
                    // Only enabled slots request a conversion
                    auto_pend_q <= auto_pend_q |
                                   {auto_ctrl_q[`GADC_AUTO_EN1_BIT], auto_ctrl_q[`GADC_AUTO_EN0_BIT]};
                end
                else
                    rate_cnt_q <= rate_cnt_q + 4'h1;
            end
        end
    end

    // Converter code comes from the analogue core: two-stage sync
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            code_sync1_q <= 12'h0;
            code_sync2_q <= 12'h0;
        end
        else
        begin
            code_sync1_q <= adc_code;
            code_sync2_q <= code_sync1_q;
        end
    end

    assign job_done = (state_q == GADC_DONE);

    // Conversion sequencer; software requests win over automatic ones
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_q      <= GADC_IDLE;
            job_q        <= '0;
            cyc_cnt_q    <= 16'h0;
            adc_power_on <= 1'b0;
            adc_sample   <= 1'b0;
            adc_channel  <= 4'h0;
        end
        else
        begin
            case (state_q)
                GADC_IDLE:
                begin
                    adc_sample   <= 1'b0;
                    adc_power_on <= ctrl1_q[`GADC_FORCE_BIT];
                    if (sw_pend_q != 2'b00 || auto_pend_q != 2'b00)
                    begin
                        if (sw_pend_q[0])
                            job_q <= '{chan: sw_sel_q[3:0], slot: 1'b0, is_auto: 1'b0};
                        else if (sw_pend_q[1])
                            job_q <= '{chan: sw_sel_q[3:0], slot: 1'b1, is_auto: 1'b0};
                        else if (auto_pend_q[0])
                            job_q <= '{chan: auto_sel_q[3:0], slot: 1'b0, is_auto: 1'b1};
                        else
                            job_q <= '{chan: auto_sel_q[7:4], slot: 1'b1, is_auto: 1'b1};
                        adc_power_on <= 1'b1;
                        cyc_cnt_q    <= ctrl1_q[`GADC_FORCE_BIT] ? 16'h0 : 16'(`GADC_PWRUP_CYC);
                        state_q      <= GADC_PWRUP;
                    end
                end
                GADC_PWRUP:
                begin
                    adc_channel <= job_q.chan;
                    if (cyc_cnt_q == 16'h0)
                    begin
                        adc_sample <= 1'b1;
                        cyc_cnt_q  <= 16'(`GADC_CONV_CYC);
                        state_q    <= GADC_CONV;
                    end
                    else
                        cyc_cnt_q <= cyc_cnt_q - 16'h1;
                end
                GADC_CONV:
                begin
                    adc_sample <= 1'b0;
                    if (cyc_cnt_q == 16'h0)
                        state_q <= GADC_DONE;
                    else
                        cyc_cnt_q <= cyc_cnt_q - 16'h1;
                end
                GADC_DONE:
                    state_q <= GADC_IDLE;
                default:
                    state_q <= GADC_IDLE;
            endcase
        end
    end

    // Result capture
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            sw_res_q[0]   <= 12'h0;
            sw_res_q[1]   <= 12'h0;
            auto_res_q[0] <= 12'h0;
            auto_res_q[1] <= 12'h0;
        end
        else if (job_done)
        begin
            if (job_q.is_auto)
                auto_res_q[job_q.slot] <= code_sync2_q;
            else
                sw_res_q[job_q.slot] <= code_sync2_q;
        end
    end

    // Events and write-one-to-clear; a new event wins over the clear
    assign thr_hit = job_done && job_q.is_auto &&
                     thr_cross(code_sync2_q, thr_of(thr_hi_q[job_q.slot], thr_lo_q[job_q.slot]));
    always_comb
    begin
        set_ev = 4'h0;
        if (job_done && !job_q.is_auto)
            set_ev[`GADC_INT_EOC0 + {31'h0, job_q.slot}] = 1'b1;
        if (thr_hit)
            set_ev[`GADC_INT_AUTO0 + {31'h0, job_q.slot}] = 1'b1;
    end
    assign clr_ev = (wr_stb && avs_address == `GADC_OFF_INT3_STAT) ? avs_writedata[3:0] : 4'h0;

    always_ff @(posedge clk)
    begin
        if (srst)
            stat_q <= 4'h0;
        else
            stat_q <= (stat_q & ~clr_ev) | set_ev;
    end

    // Interrupt level from unmasked flags
    always_ff @(posedge clk)
    begin
        if (srst)
            irq <= 1'b0;
        else
            irq <= |(stat_q & ~mask_q[3:0]);
    end

    // Delayed shutdown: armed by threshold event, aborted once the flag clears
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            shdn_arm_q   <= 2'b00;
            off_unit_q   <= 16'h0;
            off_cnt_q    <= 8'h0;
            shutdown_req <= 1'b0;
        end
        else
        begin
            if (thr_hit && auto_ctrl_q[`GADC_SHDN0_BIT + {31'h0, job_q.slot}] && shdn_arm_q == 2'b00)
            begin
                shdn_arm_q[job_q.slot] <= 1'b1;
                off_unit_q <= 16'h0;
                off_cnt_q  <= 8'h0;
            end
            else if (shdn_arm_q != 2'b00)
            begin
                if (!(stat_q[`GADC_INT_AUTO0] && shdn_arm_q[0]) &&
                    !(stat_q[`GADC_INT_AUTO1] && shdn_arm_q[1]))
                    shdn_arm_q <= 2'b00;
                else if (off_unit_q == `GADC_SWOFF_UNIT_CYC - 16'd1)
                begin
                    off_unit_q <= 16'h0;
                    if (off_cnt_q >= switch_off_delay_q)
                        shutdown_req <= 1'b1;
                    else
                        off_cnt_q <= off_cnt_q + 8'h1;
                end
                else
                    off_unit_q <= off_unit_q + 16'h1;
            end
        end
    end

endmodule // gadc_sequencer

//--- gadc_sequencer_tb.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
module gadc_sequencer_tb;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic [4:0]  avs_address = 5'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest, adc_power_on, adc_sample, irq, shutdown_req;
    logic [3:0]  adc_channel, last_chan;
    logic [11:0] adc_code, c;
    logic [7:0]  sample_count, n0;
    int          n_mismatch = 0;
    int          check_count = 0;
    int          cycles = 0;

    gadc_sequencer dut_u (.clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .adc_power_on(adc_power_on),
        .adc_sample(adc_sample), .adc_channel(adc_channel), .adc_code(adc_code), .irq(irq),
        .shutdown_req(shutdown_req));

    gadc_core_model core_u (.clk(clk), .adc_power_on(adc_power_on), .adc_sample(adc_sample),
        .adc_channel(adc_channel), .adc_code(adc_code), .sample_count(sample_count), .last_chan(last_chan));

    function automatic logic [11:0] code(input logic [3:0] ch);
        return 12'h100 + 12'h111 * {8'h0, ch};
    endfunction

    task automatic end_sim();
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One bus cycle: held until waitrequest is sampled low, then released
    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d, output logic [31:0] q);
        int n;
        n = 0;
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {24'h0, d};
        do
        begin
            @(posedge clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 20);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
        if (n >= 20)
            chk("waitrequest", 0, avs_waitrequest);
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        logic [31:0] q;
        bus(1'b0, a, 8'h0, q);
        chk($sformatf("reg %h", a), {24'h0, e}, q);
    endtask

    // Bounded wait for irq or shutdown request
    task automatic wait_for(input bit sd, input int lim);
        int n;
        n = 0;
        while ((sd ? shutdown_req : irq) !== 1'b1 && n < lim)
        begin
            @(posedge clk);
            n++;
        end
        chk(sd ? "shutdown" : "irq", 1, sd ? shutdown_req : irq);
    endtask

    always #25 clk = ~clk;

    // Hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 99000)
        begin
            n_mismatch++;
            end_sim();
        end
    end

    initial
    begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        rd(5'h3, 8'h0f);
        rd(5'h2, 8'h00);
        rd(5'h13, 8'h00);
        wr(5'h13, 8'hff);
        // Start without enable is ignored
        n0 = sample_count;
        wr(5'h0, 8'h15);
        repeat (60) @(posedge clk);
        chk("samples", n0, sample_count);
        chk("power", 0, adc_power_on);
        rd(5'h2, 8'h00);
        // Slot 0 software conversion, interrupt unmasked
        wr(5'h3, 8'h0e);
        wr(5'h0, 8'h93);
        wait_for(1'b0, 300);
        rd(5'h2, 8'h01);
        chk("channel", 3, last_chan);
        c = code(4'h3);
        rd(5'h4, {4'h0, c[11:8]});
        rd(5'h5, c[7:0]);
        wr(5'h2, 8'h01);
        rd(5'h2, 8'h00);
        chk("irq", 0, irq);
        // Slot 1 with its interrupt still masked
        wr(5'h0, 8'ha7);
        repeat (80) @(posedge clk);
        rd(5'h2, 8'h02);
        chk("irq", 0, irq);
        chk("channel", 7, last_chan);
        c = code(4'h7);
        rd(5'h10, {4'h0, c[11:8]});
        rd(5'h11, c[7:0]);
        wr(5'h2, 8'h0f);
        // Channel 0 conversion with its current source set first
        wr(5'h1, 8'h01);
        rd(5'h1, 8'h01);
        wr(5'h0, 8'h90);
        wait_for(1'b0, 300);
        chk("channel", 0, last_chan);
        rd(5'h4, 8'h01);
        wr(5'h2, 8'h0f);
        // Forced power
        wr(5'h1, 8'h02);
        repeat (4) @(posedge clk);
        chk("power", 1, adc_power_on);
        wr(5'h1, 8'h00);
        repeat (10) @(posedge clk);
        chk("power", 0, adc_power_on);
        // Both automatic slots, above and below, shutdown on slot 0
        wr(5'h6, 8'h65);
        wr(5'h8, 8'h06);
        wr(5'h9, 8'h00);
        wr(5'ha, 8'h88);
        wr(5'hb, 8'h00);
        wr(5'h12, 8'h00);
        wr(5'h3, 8'h03);
        wr(5'h7, 8'h70);
        wait_for(1'b0, 21000);
        repeat (100) @(posedge clk);
        rd(5'h2, 8'h0c);
        chk("shutdown", 0, shutdown_req);
        rd(5'hc, 8'h06);
        rd(5'hd, 8'h55);
        rd(5'he, 8'h07);
        rd(5'hf, 8'h66);
        wait_for(1'b1, 21000);
        // Second reset in mid-run
        srst <= 1'b1;
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        chk("shutdown", 0, shutdown_req);
        // Lane 0 off: write ignored, delay keeps its reset value
        avs_byteenable <= 4'he;
        wr(5'h12, 8'h00);
        avs_byteenable <= 4'hf;
        rd(5'h12, 8'h01);
        // One-unit delay, so a missed abort shows within the wait below
        wr(5'h12, 8'h00);
        // Event cleared before the delay runs out
        wr(5'h6, 8'h05);
        wr(5'h8, 8'h06);
        wr(5'h3, 8'h0b);
        wr(5'h7, 8'h50);
        wait_for(1'b0, 21000);
        wr(5'h7, 8'h00);
        wr(5'h2, 8'h04);
        repeat (20100) @(posedge clk);
        chk("shutdown", 0, shutdown_req);
        rd(5'h2, 8'h00);
        end_sim();
    end
endmodule // gadc_sequencer_tb
